// ---- dv/ccu_axi_master.sv ----
/*
 * Register bus master standing in for the processor.
 * Assumes an AXI4-Lite slave on mclk with 4-bit byte addresses.
 */
module ccu_axi_master (
    // Clock
    input wire logic mclk,
    // Write channels
    output logic awvalid,
    input wire logic awready,
    output logic [3:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    // Read channels
    output logic arvalid,
    input wire logic arready,
    output logic [3:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet bus at time zero
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wstrb, wdata} = 44'h0;
    end

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge mclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
        // Released lines show garbage, not the old value
        awaddr <= ~a;
        wdata <= ~d;
    endtask : wr

    // Read waits for the answer however long the slave stalls
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge mclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        araddr <= ~a;
    endtask : rd
endmodule : ccu_axi_master

// ---- dv/tb_top.sv ----
/*
 * Self-checking bench for the checksum unit.
 * Assumes ccu_pkg and ccu_top compiled first.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, busy;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, got, ref_crc;
    logic [1:0] bresp, rresp, resp;
    int mismatches = 0;
    int checked = 0;
    int busy_run = 0;
    int busy_max = 0;
    logic [31:0] words [3] = '{32'h12345678, 32'hFFFFFFFF, 32'h80000001};

    always #2.5 mclk = ~mclk;

    ccu_top i_ccu_top (.mclk, .rst_b, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
        .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
        .rvalid, .rready, .rdata, .rresp, .busy);

    ccu_axi_master i_ccu_axi_master (.mclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
        .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);

    ////////////////////////////////////////////////////////////
    // Reference fold, MSB first, no reflection
    function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] d);
        for (int i = 31; i >= 0; i--) begin
            c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? ccu_pkg::CRC_POLY : 32'h0);
        end
        return c;
    endfunction : fold

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic rdchk(string what, logic [3:0] a, logic [31:0] exp, logic [1:0] er = ccu_pkg::RESP_OKAY);
        i_ccu_axi_master.rd(a, got, resp);
        chk(what, exp, got);
        chk({what, " resp"}, {30'h0, er}, {30'h0, resp});
    endtask : rdchk

    task automatic wrchk(logic [3:0] a, logic [31:0] d, logic [1:0] er = ccu_pkg::RESP_OKAY);
        i_ccu_axi_master.wr(a, d, resp);
        chk("write resp", {30'h0, er}, {30'h0, resp});
    endtask : wrchk

    task automatic finish_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////
    // Longest busy stretch, compared against the fold time at the end
    always @(posedge mclk) begin
        busy_run <= (busy === 1'b1) ? busy_run + 1 : 0;
        if (busy_run > busy_max) busy_max <= busy_run;
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        rdchk("sum reset", ccu_pkg::ADDR_CHECKSUM, ccu_pkg::CHECKSUM_PRESET);
        rdchk("scratch reset", ccu_pkg::ADDR_SCRATCH, 32'h0);
        wrchk(ccu_pkg::ADDR_CHECKSUM, 32'h0);
        ref_crc = fold(ccu_pkg::CHECKSUM_PRESET, 32'h0);
        rdchk("sum zero word", ccu_pkg::ADDR_CHECKSUM, ref_crc);
        // Back-to-back writes land while the previous fold runs
        foreach (words[i]) begin
            wrchk(ccu_pkg::ADDR_CHECKSUM, words[i]);
            ref_crc = fold(ref_crc, words[i]);
        end
        rdchk("sum chained", ccu_pkg::ADDR_CHECKSUM, ref_crc);
        wrchk(ccu_pkg::ADDR_CHECKSUM, 32'hA5A5F00F);
        ref_crc = fold(ref_crc, 32'hA5A5F00F);
        rdchk("sum read write", ccu_pkg::ADDR_CHECKSUM, ref_crc);
        // Scratch byte is storage only
        wrchk(ccu_pkg::ADDR_SCRATCH, 32'h123456A5);
        rdchk("scratch", ccu_pkg::ADDR_SCRATCH, 32'h000000A5);
        rdchk("sum after scratch", ccu_pkg::ADDR_CHECKSUM, ref_crc);
        wrchk(ccu_pkg::ADDR_CONTROL, 32'h0);
        rdchk("sum after zero ctrl", ccu_pkg::ADDR_CHECKSUM, ref_crc);
        wrchk(ccu_pkg::ADDR_CONTROL, 32'h1);
        rdchk("sum restart", ccu_pkg::ADDR_CHECKSUM, ccu_pkg::CHECKSUM_PRESET);
        rdchk("scratch restart", ccu_pkg::ADDR_SCRATCH, 32'h000000A5);
        rdchk("ctrl cleared", ccu_pkg::ADDR_CONTROL, 32'h0);
        wrchk(ccu_pkg::ADDR_CHECKSUM, 32'hDEADBEEF);
        ref_crc = fold(ccu_pkg::CHECKSUM_PRESET, 32'hDEADBEEF);
        rdchk("sum fresh", ccu_pkg::ADDR_CHECKSUM, ref_crc);
        // Unmapped slot refused without side effect
        wrchk(4'hC, 32'h1, ccu_pkg::RESP_SLVERR);
        rdchk("unmapped", 4'hC, 32'h0, ccu_pkg::RESP_SLVERR);
        rdchk("sum kept", ccu_pkg::ADDR_CHECKSUM, ref_crc);
        chk("busy span", ccu_pkg::UPDATE_CYCLES, busy_max);
        finish_test();
    end

    // Watchdog, well beyond the hundred or so cycles the tests need
    initial begin
        #20000;
        mismatches++;
        $display("[ERR] watchdog expected done seen timeout");
        finish_test();
    end
endmodule : tb_top

// ---- logic/ccu_byte_step.sv ----
/*
 * Combinational step that folds one input byte into a checksum, MSB first.
 * Assumes the caller registers the result each cycle.
 */
module ccu_byte_step #(
    parameter int BITS = 8
) (
    // Running value and input slice
    input wire logic [31:0] crc_in,
    input wire logic [BITS-1:0] data_in,
    // Folded value
    output logic [31:0] crc_out
);

    // Slice must fit the 32-bit register
    if (BITS < 1 || BITS > 32) begin : g_bad_bits
        $error("BITS must be between 1 and 32");
    end

    // Serial shift unrolled across the slice, top bit first, no reflection
    always_comb begin
        logic [31:0] c;
        c = crc_in;
        for (int i = BITS - 1; i >= 0; i--) begin
            if (c[31] ^ data_in[i]) begin
                c = {c[30:0], 1'b0} ^ ccu_pkg::CRC_POLY;
            end else begin
                c = {c[30:0], 1'b0};
            end
        end
        crc_out = c;
    end

endmodule : ccu_byte_step

// ---- logic/ccu_pkg.sv ----
/*
 * Shared constants and carrier types for the checksum compute unit.
 * Assumes a single 200 MHz clock and an AXI4-Lite register slave.
 */
package ccu_pkg;

    // Register byte offsets
    localparam logic [3:0] ADDR_CHECKSUM = 4'h0;
    localparam logic [3:0] ADDR_SCRATCH = 4'h4;
    localparam logic [3:0] ADDR_CONTROL = 4'h8;

    // Reset values and field positions
    localparam logic [31:0] CHECKSUM_PRESET = 32'hFFFFFFFF;
    localparam logic [7:0] SCRATCH_RESET = 8'h00;
    localparam int RESTART_BIT = 0;

    // Fixed generator polynomial, not programmable
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;

    // Update timing: four clock cycles, eight bits per cycle
    localparam int UPDATE_CYCLES = 4;
    localparam int BITS_PER_CYCLE = 8;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Write address and data channel carrier
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } ccu_wreq_t;

    // Read answer carrier
    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } ccu_rans_t;

endpackage : ccu_pkg

// ---- logic/ccu_top.sv ----
/*
 * Checksum compute unit: AXI4-Lite slave with data port, scratch byte
 * and restart control. Assumes one clock (mclk) and a synchronous low reset.
 */
module ccu_top #(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Write address channel
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // Write data channel
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // Write response channel
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // Read address channel
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // Read data channel
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Calculation in progress
    output logic busy
);

    // Elaboration check on the address width
    if (ADDR_W < 4) begin : g_bad_width
        $error("ADDR_W must be at least 4");
    end

    // The fold shifts one byte a step, so the steps must cover the word exactly
    if (ccu_pkg::BITS_PER_CYCLE * ccu_pkg::UPDATE_CYCLES != 32) begin : g_bad_fold
        $error("fold steps do not cover a 32-bit word");
    end

    ////////////////////////////////////////////////////////////////////////////
    // State and declarations

    typedef enum logic [1:0] {
        CCU_IDLE = 2'b01,
        CCU_CALC = 2'b10
    } ccu_state_t;

    ccu_state_t state;
    ccu_pkg::ccu_wreq_t wreq;
    logic aw_held;
    logic w_held;
    logic [31:0] checksum;
    logic [31:0] shift_word;
    logic [1:0] step_cnt;
    logic [7:0] scratch_byte;
    logic restart_pending;
    logic [31:0] step_out;
    logic write_go;

    // Word-aligned register index decode, reused for both directions
    function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
        reg_sel = {a[3:2], 2'b00};
    endfunction : reg_sel

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic [3:0] s;
        s = reg_sel(a);
        // Shift rather than slice, so the default four-bit width leaves no empty range
        is_mapped = ((a >> 4) == '0) && (s == ccu_pkg::ADDR_CHECKSUM || s == ccu_pkg::ADDR_SCRATCH
            || s == ccu_pkg::ADDR_CONTROL);
    endfunction : is_mapped

    ////////////////////////////////////////////////////////////////////////////
    // Write channels: capture address and data independently

    // Address and data may arrive in either order
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wreq <= '0;
            awready <= 1'b0;
            wready <= 1'b0;
        end else begin
            awready <= !aw_held && !awready && awvalid;
            wready <= !w_held && !wready && wvalid;
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                wreq.addr <= 32'(awaddr);
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                wreq.data <= wdata;
                wreq.strb <= wstrb;
            end
            if (write_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    // Writes wait while a calculation runs, stretching the response.
    // Holding the response back is what stalls the bus master; the
    // held word is not lost, it commits once the fold is over.
    assign write_go = aw_held && w_held && !bvalid && state == CCU_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // Write response

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            bvalid <= 1'b0;
            bresp <= ccu_pkg::RESP_OKAY;
        end else if (write_go) begin
            bvalid <= 1'b1;
            bresp <= is_mapped(wreq.addr[ADDR_W-1:0]) ? ccu_pkg::RESP_OKAY : ccu_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checksum engine

    ccu_byte_step #(
        .BITS(ccu_pkg::BITS_PER_CYCLE)
    ) u_step (
        .crc_in(checksum),
        .data_in(shift_word[31:24]),
        .crc_out(step_out)
    );

    // Four-cycle fold of a whole word, one byte per cycle
    // A pending restart is applied first, before any new word starts folding
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state <= CCU_IDLE;
            checksum <= ccu_pkg::CHECKSUM_PRESET;
            shift_word <= '0;
            step_cnt <= '0;
        end else begin
            unique case (state)
                CCU_IDLE: begin
                    if (restart_pending) begin
                        checksum <= ccu_pkg::CHECKSUM_PRESET;
                    end
                    if (write_go && reg_sel(wreq.addr[ADDR_W-1:0]) == ccu_pkg::ADDR_CHECKSUM
                        && is_mapped(wreq.addr[ADDR_W-1:0])) begin
                        shift_word <= wreq.data;
                        step_cnt <= '0;
                        state <= CCU_CALC;
                    end
                end
                CCU_CALC: begin
                    checksum <= step_out;
                    shift_word <= {shift_word[23:0], 8'h00};
                    step_cnt <= step_cnt + 2'h1;
                    if (step_cnt == 2'(ccu_pkg::UPDATE_CYCLES - 1)) begin
                        state <= CCU_IDLE;
                    end
                end
            endcase
        end
    end

    // Busy mirrors the fold state, registered so the output comes from a flop
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            busy <= 1'b0;
        end else begin
            busy <= (state == CCU_CALC && step_cnt != 2'(ccu_pkg::UPDATE_CYCLES - 1))
                || (state == CCU_IDLE && write_go && reg_sel(wreq.addr[ADDR_W-1:0]) == ccu_pkg::ADDR_CHECKSUM
                && is_mapped(wreq.addr[ADDR_W-1:0]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and scratch registers

    // Restart bit: set by a one written, cleared once applied
    // A write of one wins over the clear; a zero leaves the bit alone
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            restart_pending <= 1'b0;
        end else if (write_go && reg_sel(wreq.addr[ADDR_W-1:0]) == ccu_pkg::ADDR_CONTROL
            && is_mapped(wreq.addr[ADDR_W-1:0])
            && wreq.strb[0] && wreq.data[ccu_pkg::RESTART_BIT]) begin
            restart_pending <= 1'b1;
        end else if (state == CCU_IDLE) begin
            restart_pending <= 1'b0;
        end
    end

    // Scratch byte: untouched by restart, never fed to the engine
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            scratch_byte <= ccu_pkg::SCRATCH_RESET;
        end else if (write_go && reg_sel(wreq.addr[ADDR_W-1:0]) == ccu_pkg::ADDR_SCRATCH
            && is_mapped(wreq.addr[ADDR_W-1:0]) && wreq.strb[0]) begin
            scratch_byte <= wreq.data[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel

    // One read at a time; checksum read waits for a running fold to end
    // Answering early would hand back a half-folded value, so arready is held off
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= ccu_pkg::RESP_OKAY;
        end else begin
            arready <= !arready && !rvalid && arvalid && state == CCU_IDLE && !restart_pending;
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= is_mapped(araddr) ? ccu_pkg::RESP_OKAY : ccu_pkg::RESP_SLVERR;
                unique case (reg_sel(araddr))
                    ccu_pkg::ADDR_CHECKSUM: rdata <= is_mapped(araddr) ? checksum : '0;
                    ccu_pkg::ADDR_SCRATCH: rdata <= is_mapped(araddr) ? {24'h000000, scratch_byte} : '0;
                    default: rdata <= '0; // Control reads zero, write-only
                endcase
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_word_taken;
        state == CCU_IDLE && write_go && reg_sel(wreq.addr[ADDR_W-1:0]) == ccu_pkg::ADDR_CHECKSUM
            && is_mapped(wreq.addr[ADDR_W-1:0]);
    endsequence

    sequence s_fold_done;
        ##4 state == CCU_CALC && step_cnt == 2'(ccu_pkg::UPDATE_CYCLES - 1) ##1 state == CCU_IDLE;
    endsequence

    sequence s_ctrl_zero;
        write_go && reg_sel(wreq.addr[ADDR_W-1:0]) == ccu_pkg::ADDR_CONTROL
            && !wreq.data[ccu_pkg::RESTART_BIT];
    endsequence

    a_update_four_cycles: assert property (@(posedge mclk) disable iff (!rst_b)
        s_word_taken |-> s_fold_done)
        else $error("checksum update did not end in four cycles");

    a_no_write_busy: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(bvalid) |-> $past(state) == CCU_IDLE)
        else $error("write accepted during calculation");

    a_restart_preset: assert property (@(posedge mclk) disable iff (!rst_b)
        state == CCU_IDLE && restart_pending |=> checksum == ccu_pkg::CHECKSUM_PRESET)
        else $error("restart did not preset checksum");

    a_restart_clears: assert property (@(posedge mclk) disable iff (!rst_b)
        restart_pending && state == CCU_IDLE && !write_go |=> !restart_pending)
        else $error("restart bit did not clear");

    a_scratch_keeps: assert property (@(posedge mclk) disable iff (!rst_b)
        restart_pending && !write_go |=> $stable(scratch_byte))
        else $error("scratch changed on restart");

    a_checksum_idle: assert property (@(posedge mclk) disable iff (!rst_b)
        state == CCU_IDLE && !restart_pending |=> $stable(checksum))
        else $error("checksum changed while idle");

    a_read_result: assert property (@(posedge mclk) disable iff (!rst_b)
        arvalid && arready && reg_sel(araddr) == ccu_pkg::ADDR_CHECKSUM && is_mapped(araddr)
            |=> rdata == $past(checksum))
        else $error("data port read is not the checksum");

    a_fold_step: assert property (@(posedge mclk) disable iff (!rst_b)
        state == CCU_CALC |=> checksum == $past(step_out))
        else $error("fold did not take step result");

    a_busy_track: assert property (@(posedge mclk) disable iff (!rst_b)
        s_word_taken |=> busy [*4] ##1 !busy)
        else $error("busy not high for four cycles");

    // Busy is the registered image of the fold state
    a_busy_state: assert property (@(posedge mclk) disable iff (!rst_b)
        busy == (state == CCU_CALC))
        else $error("busy does not match fold state");

    // A taken word is loaded whole into the shifter
    a_word_loaded: assert property (@(posedge mclk) disable iff (!rst_b)
        s_word_taken |=> state == CCU_CALC && shift_word == $past(wreq.data))
        else $error("written word not loaded for folding");

    // Write response stands until the master takes it
    a_bresp_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before taken");

    // Read data stands until the master takes it
    a_rdata_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped before taken");

    // A read is only accepted once no fold or restart is outstanding
    a_read_waits: assert property (@(posedge mclk) disable iff (!rst_b)
        arready |-> $past(state == CCU_IDLE && !restart_pending))
        else $error("read accepted while checksum unsettled");

    // The restart bit lives for one cycle only
    a_restart_once: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(restart_pending) |=> !restart_pending)
        else $error("restart bit did not clear itself");

    // A zero written to the control register starts nothing
    a_zero_ctrl: assert property (@(posedge mclk) disable iff (!rst_b)
        s_ctrl_zero |=> !restart_pending)
        else $error("zero control write started a restart");

    // The scratch byte changes only through a bus write
    a_scratch_source: assert property (@(posedge mclk) disable iff (!rst_b)
        $changed(scratch_byte) |-> $past(write_go))
        else $error("scratch byte changed without a write");

endmodule : ccu_top
